// [inc/smc_pkg.sv]
/*
 * smc_pkg: shared constants and types of the switch memory command unit.
 * assumes: one system clock, register port with one-cycle read latency.
 */
package smc_pkg;

   // ------------------------------------------------------------
   // register offsets on the plain register port
   // ------------------------------------------------------------
   localparam logic [2:0] OFS_DATA    = 3'h0;  // memory_access_data_reg
   localparam logic [2:0] OFS_ADDR    = 3'h1;  // memory_access_address_reg
   localparam logic [2:0] OFS_CMD     = 3'h2;  // memory_access_command_reg
   localparam logic [2:0] OFS_STATUS  = 3'h3;  // device_status_reg
   localparam logic [2:0] OFS_SUBCH   = 3'h4;  // subchannel_select_reg
   localparam logic [2:0] OFS_OPMODE  = 3'h5;  // operation_mode_reg

   // field positions
   localparam int STATUS_BUSY_BIT = 0;   // memory_op_busy
   localparam int OPMODE_OD_BIT   = 0;   // open_drain_select

   // reset values
   localparam logic [7:0] RST_REG8  = 8'h00;

   // ------------------------------------------------------------
   // command byte encodings
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_IDLE_8    = 8'h08;
   localparam logic [7:0] CMD_IDLE_74   = 8'h18;
   localparam logic [7:0] CMD_IDLE_30   = 8'h10;
   localparam logic [7:0] CMD_IDLE_76   = 8'h38;
   localparam logic [7:0] CMD_IDLE_54   = 8'h30;
   localparam logic [7:0] CMD_IDLE_32   = 8'h28;
   localparam logic [7:0] CMD_IDLE_10   = 8'h20;
   localparam logic [7:0] CMD_DM_RD     = 8'h88;
   localparam logic [7:0] CMD_TS_WR     = 8'h60;
   localparam logic [7:0] CMD_TS_FILL   = 8'h68;
   localparam logic [7:0] CMD_TS_RD     = 8'he0;
   localparam logic [7:0] CMD_CMD_WR    = 8'h48;
   localparam logic [7:0] CMD_CMD_RD    = 8'hc8;
   localparam logic [2:0] CMD_COMBINED  = 3'h7;   // bits 6:4 of X111 class
   localparam int         CMD_READ_BIT  = 7;

   // control memory codes
   localparam logic [3:0] CODE_DISABLE  = 4'h0;
   localparam logic [3:0] CODE_SW8      = 4'h1;
   localparam logic [3:0] CODE_SW4_LO   = 4'h2;
   localparam logic [3:0] CODE_SW4_HI   = 4'h3;
   localparam logic [3:0] CODE_SW2_10   = 4'h4;
   localparam logic [3:0] CODE_SW2_32   = 4'h5;
   localparam logic [3:0] CODE_SW2_54   = 4'h6;
   localparam logic [3:0] CODE_SW2_76   = 4'h7;
   localparam logic [3:0] CODE_PRE_A    = 4'h8;
   localparam logic [3:0] CODE_UP       = 4'h9;
   localparam logic [3:0] CODE_PRE_B    = 4'ha;
   localparam logic [3:0] CODE_PRE_C    = 4'hb;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam logic [10:0] FILL_CYCLES  = 11'h40b;

   typedef enum logic [2:0] {
      SMC_IDLE = 3'b001,
      SMC_EXEC = 3'b010,
      SMC_FILL = 3'b100
   } smc_state_e;

   // decoded meaning of a control memory code
   typedef struct packed {
      logic       sw;       // switched channel
      logic       pre;      // preprocessed channel
      logic       up;       // microprocessor channel
      logic       sub;      // subchannel, gated by subchannel select
      logic [7:0] bits;     // carried bit positions
   } smc_chan_s;

   // register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } smc_req_s;

   // downstream interface timeslot bit to drive
   typedef struct packed {
      logic [6:0] slot;
      logic [2:0] bit_pos;
      logic       bit_val;
      logic       valid;
   } smc_cfi_s;

endpackage : smc_pkg

// [logic/smc_unit.sv]
/*
 * smc_unit: indirect command unit for the control and data memories of a
 * timeslot switch, plus the downstream configurable-interface driver control.
 * assumes: host keeps to the busy flag; register port strobes are one cycle.
 */
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module smc_unit #(
   parameter int SLOTS = 128
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire smc_pkg::smc_req_s req,
   output logic [7:0]             rdata,
   input  wire smc_pkg::smc_cfi_s cfi_in,
   output logic                   cfi_out,
   output logic                   cfi_oe,
   output logic                   busy
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      smc_pkg::smc_state_e fsm;
      logic [7:0]          data;
      logic [7:0]          addr;
      logic [7:0]          cmd;
      logic [7:0]          subch;
      logic                od_sel;
      logic [10:0]         cnt;
      logic [7:0]          rdata;
      logic                cfi_out;
      logic                cfi_oe;
   } smc_st_s;

   smc_st_s st_ff;
   smc_st_s nxt_st;

   // memories: control data/code indexed by full address (bit 7 = upstream),
   // data memory likewise, tristate field only for upstream slots
   logic [7:0] cm_data_mem [2*SLOTS];
   logic [3:0] cm_code_mem [2*SLOTS];
   logic [7:0] dm_data_mem [2*SLOTS];
   logic [3:0] ts_mem      [SLOTS];

   logic       cm_data_we;
   logic       cm_code_we;
   logic       dm_we;
   logic [7:0] dm_mask;
   logic       ts_we;
   logic [6:0] ts_idx;
   logic [7:0] up_idx;
   logic [3:0] ds_code;
   smc_pkg::smc_chan_s ds_chan;
   logic       ds_active;

   // ------------------------------------------------------------
   // code decoding
   // ------------------------------------------------------------
   function automatic smc_pkg::smc_chan_s decode_code(input logic [3:0] code);
      smc_pkg::smc_chan_s c;
      c = '0;
      case (code)
         smc_pkg::CODE_DISABLE: c.bits = 8'h00;
         smc_pkg::CODE_SW8: begin
            c.sw   = 1'b1;
            c.bits = 8'hff;
         end
         smc_pkg::CODE_SW4_HI: begin
            c.sw   = 1'b1;
            c.sub  = 1'b1;
            c.bits = 8'hf0;
         end
         smc_pkg::CODE_SW4_LO: begin
            c.sw   = 1'b1;
            c.sub  = 1'b1;
            c.bits = 8'h0f;
         end
         smc_pkg::CODE_SW2_76: begin
            c.sw   = 1'b1;
            c.sub  = 1'b1;
            c.bits = 8'hc0;
         end
         smc_pkg::CODE_SW2_54: begin
            c.sw   = 1'b1;
            c.sub  = 1'b1;
            c.bits = 8'h30;
         end
         smc_pkg::CODE_SW2_32: begin
            c.sw   = 1'b1;
            c.sub  = 1'b1;
            c.bits = 8'h0c;
         end
         smc_pkg::CODE_SW2_10: begin
            c.sw   = 1'b1;
            c.sub  = 1'b1;
            c.bits = 8'h03;
         end
         smc_pkg::CODE_PRE_A,
         smc_pkg::CODE_PRE_B,
         smc_pkg::CODE_PRE_C: begin
            c.pre  = 1'b1;
            c.bits = 8'hff;
         end
         smc_pkg::CODE_UP: begin
            c.up   = 1'b1;
            c.bits = 8'hff;
         end
         default: c.bits = 8'h00;
      endcase
      return c;
   endfunction : decode_code

   // idle write commands carry their own bit mask
   function automatic logic [7:0] idle_mask(input logic [7:0] cmd);
      case (cmd)
         smc_pkg::CMD_IDLE_8:  idle_mask = 8'hff;
         smc_pkg::CMD_IDLE_74: idle_mask = 8'hf0;
         smc_pkg::CMD_IDLE_30: idle_mask = 8'h0f;
         smc_pkg::CMD_IDLE_76: idle_mask = 8'hc0;
         smc_pkg::CMD_IDLE_54: idle_mask = 8'h30;
         smc_pkg::CMD_IDLE_32: idle_mask = 8'h0c;
         smc_pkg::CMD_IDLE_10: idle_mask = 8'h03;
         default:              idle_mask = 8'h00;
      endcase
   endfunction : idle_mask

   // ------------------------------------------------------------
   // memory indices and downstream decode
   // ------------------------------------------------------------
   // slot fields are seven bits wide, so SLOTS above 128 needs wider indices
   assign up_idx    = {1'b1, st_ff.addr[6:0]};
   assign ds_code   = cm_code_mem[{1'b0, cfi_in.slot}];
   assign ds_chan   = decode_code(ds_code);
   // subchannels only drive where both their own bits and the select mask agree
   assign ds_active = cfi_in.valid && ds_code != smc_pkg::CODE_DISABLE &&
                      ds_chan.bits[cfi_in.bit_pos] &&
                      (!ds_chan.sub || st_ff.subch[cfi_in.bit_pos]);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st     = st_ff;
      cm_data_we = 1'b0;
      cm_code_we = 1'b0;
      dm_we      = 1'b0;
      dm_mask    = 8'h00;
      ts_we      = 1'b0;
      ts_idx     = st_ff.addr[6:0];

      // register port; data, address and command writes are refused while a command runs
      nxt_st.rdata = 8'h00;
      if (req.rd) begin
         case (req.addr)
            smc_pkg::OFS_DATA:   nxt_st.rdata = st_ff.data;
            smc_pkg::OFS_ADDR:   nxt_st.rdata = st_ff.addr;
            smc_pkg::OFS_CMD:    nxt_st.rdata = st_ff.cmd;
            smc_pkg::OFS_STATUS: nxt_st.rdata = {7'h00, st_ff.fsm != smc_pkg::SMC_IDLE};
            smc_pkg::OFS_SUBCH:  nxt_st.rdata = st_ff.subch;
            smc_pkg::OFS_OPMODE: nxt_st.rdata = {7'h00, st_ff.od_sel};
            default:             nxt_st.rdata = 8'h00;
         endcase
      end
      // mode registers stay writable while a command runs
      if (req.wr) begin
         case (req.addr)
            smc_pkg::OFS_SUBCH:  nxt_st.subch  = req.wdata;
            smc_pkg::OFS_OPMODE: nxt_st.od_sel = req.wdata[smc_pkg::OPMODE_OD_BIT];
            default: ;
         endcase
      end
      // a write while busy is dropped, not queued
      if (req.wr && st_ff.fsm == smc_pkg::SMC_IDLE) begin
         case (req.addr)
            smc_pkg::OFS_DATA: nxt_st.data = req.wdata;
            smc_pkg::OFS_ADDR: nxt_st.addr = req.wdata;
            smc_pkg::OFS_CMD: begin
               nxt_st.cmd = req.wdata;
               nxt_st.cnt = 11'h000;
               nxt_st.fsm = (req.wdata == smc_pkg::CMD_TS_FILL) ?
                            smc_pkg::SMC_FILL : smc_pkg::SMC_EXEC;
            end
            default: ;
         endcase
      end

      // command execution; read results reach the data register as busy drops
      case (st_ff.fsm)
         smc_pkg::SMC_IDLE: ;
         smc_pkg::SMC_EXEC: begin
            nxt_st.fsm = smc_pkg::SMC_IDLE;
            // a combined write lands both fields on one edge, never a half-updated slot
            if (st_ff.cmd[6:4] == smc_pkg::CMD_COMBINED) begin
               if (st_ff.cmd[smc_pkg::CMD_READ_BIT]) begin
                  nxt_st.data = {4'h0, cm_code_mem[st_ff.addr]};
               end else begin
                  cm_data_we = 1'b1;
                  cm_code_we = 1'b1;
               end
            end else begin
               case (st_ff.cmd)
                  smc_pkg::CMD_DM_RD:  nxt_st.data = dm_data_mem[st_ff.addr];
                  smc_pkg::CMD_TS_WR:  ts_we = 1'b1;
                  smc_pkg::CMD_TS_RD:  nxt_st.data = {4'h0, ts_mem[ts_idx]};
                  smc_pkg::CMD_CMD_WR: cm_data_we = 1'b1;
                  smc_pkg::CMD_CMD_RD: nxt_st.data = cm_data_mem[st_ff.addr];
                  default: begin
                     dm_mask = idle_mask(st_ff.cmd);
                     dm_we   = dm_mask != 8'h00;
                  end
               endcase
            end
         end
         smc_pkg::SMC_FILL: begin
            // every slot is written in the first cycles; busy then holds
            // for the full documented duration so software timing matches
            ts_idx = st_ff.cnt[6:0];
            ts_we  = st_ff.cnt < 11'(SLOTS);
            nxt_st.cnt = st_ff.cnt + 11'h001;
            if (st_ff.cnt == smc_pkg::FILL_CYCLES - 11'h001) begin
               nxt_st.fsm = smc_pkg::SMC_IDLE;
            end
         end
         default: nxt_st.fsm = smc_pkg::SMC_IDLE;
      endcase

      // value and enable are registered together so they change on one edge
      // downstream driver; open drain never drives a one
      if (st_ff.od_sel) begin
         nxt_st.cfi_out = 1'b0;
         nxt_st.cfi_oe  = ds_active && !cfi_in.bit_val;
      end else begin
         nxt_st.cfi_out = ds_active && cfi_in.bit_val;
         nxt_st.cfi_oe  = ds_active;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // memories keep their contents across reset
         st_ff         <= '0;
         st_ff.fsm     <= smc_pkg::SMC_IDLE;
         st_ff.data    <= smc_pkg::RST_REG8;
         st_ff.addr    <= smc_pkg::RST_REG8;
         st_ff.cmd     <= smc_pkg::RST_REG8;
         st_ff.subch   <= smc_pkg::RST_REG8;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // memories
   // ------------------------------------------------------------
   // memories are not reset; software initialises them before use
   always_ff @(posedge clk) begin
      if (cm_data_we) begin
         cm_data_mem[st_ff.addr] <= st_ff.data;
      end
      if (cm_code_we) begin
         cm_code_mem[st_ff.addr] <= st_ff.cmd[3:0];
      end
      if (dm_we) begin
         dm_data_mem[up_idx] <= (dm_data_mem[up_idx] & ~dm_mask) | (st_ff.data & dm_mask);
      end
      if (ts_we) begin
         ts_mem[ts_idx] <= st_ff.data[3:0];
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdata   = st_ff.rdata;
   assign cfi_out = st_ff.cfi_out;
   assign cfi_oe  = st_ff.cfi_oe;
   // busy is decoded from the state so the flag and the status bit never disagree
   assign busy    = st_ff.fsm != smc_pkg::SMC_IDLE;

endmodule : smc_unit

// [tb/smc_chk.sv]
/* smc_chk: port-level checks on the command unit.
   assumes: bound into smc_unit; one clock, asynchronous active-low reset. */
`timescale 1ns/100ps
module smc_chk #(
   parameter int SLOTS = 128
) (
   input wire logic              clk,
   input wire logic              arst_n,
   input wire smc_pkg::smc_req_s req,
   input wire logic [7:0]        rdata,
   input wire smc_pkg::smc_cfi_s cfi_in,
   input wire logic              cfi_out,
   input wire logic              cfi_oe,
   input wire logic              busy
);
   // open-drain select is only visible as a register write, so it is shadowed here
   logic        od_ff;
   logic        fill_ff;
   logic [11:0] run_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         od_ff   <= 1'b0;
         fill_ff <= 1'b0;
         run_ff  <= 12'h000;
      end else begin
         if (req.wr && req.addr == smc_pkg::OFS_OPMODE) od_ff <= req.wdata[smc_pkg::OPMODE_OD_BIT];
         if (req.wr && req.addr == smc_pkg::OFS_CMD && !busy) fill_ff <= req.wdata == smc_pkg::CMD_TS_FILL;
         run_ff <= busy ? run_ff + 12'h001 : 12'h000;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence cmd_s; req.wr && req.addr == smc_pkg::OFS_CMD && !busy; endsequence
   sequence one_busy_s; busy ##1 !busy; endsequence
   busy_start_a: assert property (cmd_s |=> busy)
      else $error("busy not raised by command");
   single_cmd_a: assert property (cmd_s ##0 req.wdata != smc_pkg::CMD_TS_FILL |=> one_busy_s)
      else $error("single command busy not one cycle");
   fill_hold_a: assert property (busy |-> run_ff < {1'b0, smc_pkg::FILL_CYCLES})
      else $error("busy run too long");
   busy_len_a: assert property ($fell(busy) |-> run_ff == (fill_ff ? {1'b0, smc_pkg::FILL_CYCLES} : 12'h001))
      else $error("busy run length wrong");
   read_idle_a: assert property (!req.rd |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   status_read_a: assert property (req.rd && req.addr == smc_pkg::OFS_STATUS |=> rdata == {7'h00, $past(busy)})
      else $error("status read does not show busy");
   drive_idle_a: assert property (!cfi_in.valid |=> !cfi_oe)
      else $error("driver active without valid bit");
   od_low_a: assert property ($past(od_ff) && cfi_oe |-> !cfi_out && !$past(cfi_in.bit_val))
      else $error("open drain drove a one");
   pp_out_a: assert property (!$past(od_ff) |-> cfi_out == (cfi_oe && $past(cfi_in.bit_val)))
      else $error("push-pull output wrong");
endmodule : smc_chk
bind smc_unit smc_chk #(.SLOTS(SLOTS)) u_chk (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
   .cfi_in(cfi_in), .cfi_out(cfi_out), .cfi_oe(cfi_oe), .busy(busy));

// [tb/smc_host.sv]
/* smc_host: register-port master in place of the host processor.
   assumes: strobes sampled on rising clk; read data stands one cycle after a read. */
`timescale 1ns/100ps
module smc_host (
   input  wire logic         clk,
   input  wire logic         busy,
   input  wire logic [7:0]   rdata,
   output smc_pkg::smc_req_s req
);
   initial req = '0;
   // address and data are scrambled once the strobe drops, so nothing leans on stale values
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
      @(negedge clk);
      d = rdata;
   endtask : rd
   // n counts busy cycles; 2000 means the unit is stuck
   task automatic wait_idle(output int n);
      n = 0;
      @(negedge clk);
      while (busy !== 1'b0 && n < 2000) begin
         n++;
         @(negedge clk);
      end
   endtask : wait_idle
endmodule : smc_host

// [tb/testbench.sv]
/* testbench: directed scenarios for the switch memory command unit.
   assumes: smc_host drives the register port; smc_chk is bound in. */
`timescale 1ns/100ps
module testbench;
   localparam logic [7:0] MASK = 8'h5a;
   logic              clk;
   logic              arst_n;
   smc_pkg::smc_req_s req;
   smc_pkg::smc_cfi_s cfi_in;
   logic [7:0]        rdata;
   logic              cfi_out;
   logic              cfi_oe;
   logic              busy;
   int                bad_count;
   int                checks_done;
   smc_unit u_dut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .cfi_in(cfi_in), .cfi_out(cfi_out),
                   .cfi_oe(cfi_oe), .busy(busy));
   smc_host u_host (.clk(clk), .busy(busy), .rdata(rdata), .req(req));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(output int n);
      u_host.wait_idle(n);
      if (n >= 2000) begin
         bad_count++;
         results();
      end
   endtask : idle
   // every command is followed by its busy run, which is checked against its fixed length
   task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
      int n;
      u_host.wr(smc_pkg::OFS_DATA, d);
      u_host.wr(smc_pkg::OFS_ADDR, a);
      u_host.wr(smc_pkg::OFS_CMD, c);
      idle(n);
      chk(12'(n), c == smc_pkg::CMD_TS_FILL ? {1'b0, smc_pkg::FILL_CYCLES} : 12'h001);
   endtask : op
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      logic [7:0] d;
      u_host.rd(a, d);
      chk({4'h0, d & m}, {4'h0, e});
   endtask : rd_chk
   task automatic t_regs();
      rd_chk(smc_pkg::OFS_STATUS, 8'h00);
      u_host.wr(smc_pkg::OFS_STATUS, 8'hff);
      u_host.wr(3'h7, 8'hff);
      rd_chk(smc_pkg::OFS_STATUS, 8'h00);
      rd_chk(3'h7, 8'h00);
      rd_chk(smc_pkg::OFS_SUBCH, 8'h00);
      rd_chk(smc_pkg::OFS_OPMODE, 8'h00);
      op(8'h3c, 8'h00, 8'h01);
      rd_chk(smc_pkg::OFS_ADDR, 8'h3c);
      rd_chk(smc_pkg::OFS_CMD, 8'h01);
   endtask : t_regs
   task automatic t_cm();
      for (int i = 0; i < 12; i++) begin
         op(8'(i), 8'h40 + 8'(i), 8'h70 | 8'(i));
      end
      for (int i = 0; i < 12; i++) begin
         op(8'(i), 8'h00, 8'hff - 8'(i));
         rd_chk(smc_pkg::OFS_DATA, 8'(i));
         op(8'(i), 8'h00, smc_pkg::CMD_CMD_RD);
         rd_chk(smc_pkg::OFS_DATA, 8'h40 + 8'(i));
      end
      op(8'h05, 8'hc3, smc_pkg::CMD_CMD_WR);
      op(8'h05, 8'h00, 8'hf0);
      rd_chk(smc_pkg::OFS_DATA, 8'h05);
      op(8'h05, 8'h00, smc_pkg::CMD_CMD_RD);
      rd_chk(smc_pkg::OFS_DATA, 8'hc3);
   endtask : t_cm
   function automatic logic act(input int c, input int p);
      logic f;
      f = c == 2 ? p < 4 : c == 3 ? p > 3 : p / 2 == c - 4;
      if (c == 0) return 1'b0;
      if (c == 1 || c > 7) return 1'b1;
      return f && MASK[p];
   endfunction : act
   // slots 0..11 hold codes 0..11; each bit position is driven with 0, 1 and not valid
   task automatic t_cfi();
      logic a;
      logic v;
      u_host.wr(smc_pkg::OFS_SUBCH, MASK);
      for (int od = 0; od < 2; od++) begin
         u_host.wr(smc_pkg::OFS_OPMODE, 8'(od));
         for (int k = 0; k < 288; k++) begin
            @(posedge clk);
            cfi_in <= '{slot: 7'(k / 24), bit_pos: 3'(k / 3 % 8), bit_val: k % 3 != 0, valid: k % 3 != 2};
            @(posedge clk);
            @(negedge clk);
            a = k % 3 != 2 && act(k / 24, k / 3 % 8);
            v = k % 3 != 0;
            chk({10'h000, cfi_out, cfi_oe}, {10'h000, od == 0 && v && a, a && (od == 0 || !v)});
         end
      end
   endtask : t_cfi
   // sub-field values repeat across the field so either alignment of the idle value agrees
   task automatic t_dm();
      logic [7:0] cmd [7] = '{8'h08, 8'h18, 8'h10, 8'h38, 8'h30, 8'h28, 8'h20};
      logic [7:0] dat [7] = '{8'h00, 8'h99, 8'h33, 8'hff, 8'h00, 8'haa, 8'h55};
      logic [7:0] res [7] = '{8'h00, 8'h90, 8'h93, 8'hd3, 8'hc3, 8'hcb, 8'hc9};
      for (int i = 0; i < 7; i++) begin
         op(8'h12, dat[i], cmd[i]);
         op(8'h92, 8'h00, smc_pkg::CMD_DM_RD);
         rd_chk(smc_pkg::OFS_DATA, res[i]);
      end
   endtask : t_dm
   task automatic t_ts();
      int n;
      u_host.wr(smc_pkg::OFS_DATA, 8'hf9);
      u_host.wr(smc_pkg::OFS_CMD, smc_pkg::CMD_TS_FILL);
      u_host.wr(smc_pkg::OFS_DATA, 8'h30);
      u_host.wr(smc_pkg::OFS_ADDR, 8'h55);
      rd_chk(smc_pkg::OFS_STATUS, 8'h01);
      idle(n);
      rd_chk(smc_pkg::OFS_DATA, 8'hf9);
      rd_chk(smc_pkg::OFS_ADDR, 8'h92);
      rd_chk(smc_pkg::OFS_CMD, smc_pkg::CMD_TS_FILL);
      u_host.wr(smc_pkg::OFS_CMD, smc_pkg::CMD_TS_FILL);
      idle(n);
      chk(12'(n), {1'b0, smc_pkg::FILL_CYCLES});
      op(8'h06, 8'h00, smc_pkg::CMD_TS_RD);
      rd_chk(smc_pkg::OFS_DATA, 8'h09, 8'h0f);
      op(8'h05, 8'h06, smc_pkg::CMD_TS_WR);
      op(8'h05, 8'h00, smc_pkg::CMD_TS_RD);
      rd_chk(smc_pkg::OFS_DATA, 8'h06, 8'h0f);
      op(8'h06, 8'h00, smc_pkg::CMD_TS_RD);
      rd_chk(smc_pkg::OFS_DATA, 8'h09, 8'h0f);
   endtask : t_ts
   initial begin
      arst_n = 1'b0;
      cfi_in = '0;
      bad_count = 0;
      checks_done = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      t_cm();
      t_cfi();
      t_dm();
      t_ts();
      results();
   end
endmodule : testbench
